// file: rtl/vrc_regs.vh
// Register map, field positions and reset values of the reference control block
`ifndef VRC_REGS_VH
`define VRC_REGS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define VRC_LEVEL_SELECT_IDX 4'h0
`define VRC_FORCE_ENABLE_IDX 4'h1
`define VRC_ADDR_W 4
`define VRC_LEVEL_SELECT_ADDR 4'h0
`define VRC_FORCE_ENABLE_ADDR 4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VRC_CONV_SEL_HI 6
`define VRC_CONV_SEL_LO 4
`define VRC_SHARED_SEL_HI 2
`define VRC_SHARED_SEL_LO 0
`define VRC_CONV_FORCE_BIT 1
`define VRC_SHARED_FORCE_BIT 0

// ----------------------------------------------------------------
// Level codes and reset values
// ----------------------------------------------------------------
`define VRC_LVL_0V55 3'h0
`define VRC_LVL_1V1 3'h1
`define VRC_LVL_2V5 3'h2
`define VRC_LVL_4V34 3'h3
`define VRC_LVL_1V5 3'h4
`define VRC_LEVEL_SELECT_RST 8'h00
`define VRC_FORCE_ENABLE_RST 8'h00
`define VRC_LEVEL_SELECT_MASK 8'h77
`define VRC_FORCE_ENABLE_MASK 8'h03

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define VRC_RESP_OKAY 2'h0
`define VRC_RESP_SLVERR 2'h2

`endif

// file: rtl/vrc_level_decode.v
// Level code decoder, one-hot over the five reference levels
`timescale 1ns/1ns
`include "vrc_regs.vh"
module vrc_level_decode (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] sel,
    output reg [4:0] level_onehot_q
);
    reg [4:0] level_onehot_d;

    // ----------------------------------------------------------------
    // Decode: bit0 0.55V, bit1 1.1V, bit2 2.5V, bit3 4.34V, bit4 1.5V
    // ----------------------------------------------------------------
    always @* begin
        case (sel)
            `VRC_LVL_0V55: level_onehot_d = 5'h01;
            `VRC_LVL_1V1: level_onehot_d = 5'h02;
            `VRC_LVL_2V5: level_onehot_d = 5'h04;
            `VRC_LVL_4V34: level_onehot_d = 5'h08;
            default: level_onehot_d = 5'h10;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            level_onehot_q <= 5'h01;
        end else begin
            level_onehot_q <= level_onehot_d;
        end
    end
endmodule // vrc_level_decode

// file: rtl/vrc_reference_control.v
// Reference source control with AXI4-Lite register access
`timescale 1ns/1ns
`include "vrc_regs.vh"
module vrc_reference_control (
    input wire aclk,
    input wire aresetn,
    input wire [`VRC_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`VRC_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire converter_request,
    input wire comparator_request,
    input wire output_conv_request,
    output reg converter_ref_en_q,
    output reg shared_ref_en_q,
    output reg [2:0] converter_level_q,
    output reg [2:0] shared_level_q,
    output wire [4:0] converter_level_onehot_q,
    output wire [4:0] shared_level_onehot_q
);
    reg [7:0] level_select_register_q;
    reg [7:0] force_enable_register_q;
    reg aw_held_q;
    reg w_held_q;
    reg [`VRC_ADDR_W-1:0] aw_addr_q;
    reg [7:0] w_data_q;
    reg w_strb0_q;
    wire aw_take;
    wire w_take;
    wire do_write;
    wire [`VRC_ADDR_W-1:0] wr_addr;
    wire [7:0] wr_data;
    wire wr_strb0;
    wire converter_force_on;
    wire shared_force_on;
    wire wr_hit_level;
    wire wr_hit_force;
    wire wr_store;
    reg [31:0] rd_data;
    reg [1:0] rd_resp;
    localparam SRC_COUNT = 2;
    wire [2:0] src_sel [0:SRC_COUNT-1];
    wire [4:0] src_onehot [0:SRC_COUNT-1];
    genvar gi;

    // ----------------------------------------------------------------
    // Write channels: address and data taken in either order
    // ----------------------------------------------------------------
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = (aw_take || aw_held_q) && (w_take || w_held_q) && !s_axi_bvalid;
    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata[7:0];
    assign wr_strb0 = w_held_q ? w_strb0_q : s_axi_wstrb[0];
    assign wr_hit_level = (wr_addr == `VRC_LEVEL_SELECT_ADDR);
    assign wr_hit_force = (wr_addr == `VRC_FORCE_ENABLE_ADDR);
    assign wr_store = do_write && wr_strb0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VRC_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {`VRC_ADDR_W{1'b0}};
            w_data_q <= 8'h00;
            w_strb0_q <= 1'b0;
        end else begin
            s_axi_awready <= !s_axi_awready && !aw_held_q && !s_axi_bvalid && !do_write
                && s_axi_awvalid;
            s_axi_wready <= !s_axi_wready && !w_held_q && !s_axi_bvalid && !do_write
                && s_axi_wvalid;
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_hit_level || wr_hit_force) begin
                    s_axi_bresp <= `VRC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `VRC_RESP_SLVERR;
                end
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata[7:0];
                    w_strb0_q <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            level_select_register_q <= `VRC_LEVEL_SELECT_RST;
            force_enable_register_q <= `VRC_FORCE_ENABLE_RST;
        end else if (wr_store) begin
            if (wr_hit_level) begin
                level_select_register_q <= wr_data & `VRC_LEVEL_SELECT_MASK;
            end
            if (wr_hit_force) begin
                force_enable_register_q <= wr_data & `VRC_FORCE_ENABLE_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data select
    // ----------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        rd_resp = `VRC_RESP_SLVERR;
        case (s_axi_araddr)
            `VRC_LEVEL_SELECT_ADDR: begin
                rd_data = {24'h00_0000, level_select_register_q};
                rd_resp = `VRC_RESP_OKAY;
            end
            `VRC_FORCE_ENABLE_ADDR: begin
                rd_data = {24'h00_0000, force_enable_register_q};
                rd_resp = `VRC_RESP_OKAY;
            end
            default: begin
                rd_data = 32'h0000_0000;
                rd_resp = `VRC_RESP_SLVERR;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `VRC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Source enables and level outputs
    // ----------------------------------------------------------------
    assign converter_force_on = force_enable_register_q[`VRC_CONV_FORCE_BIT];
    assign shared_force_on = force_enable_register_q[`VRC_SHARED_FORCE_BIT];

    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_ref_en_q <= 1'b0;
            shared_ref_en_q <= 1'b0;
        end else begin
            // Independent sources, enable is force OR request
            converter_ref_en_q <= converter_force_on
                || converter_request;
            shared_ref_en_q <= shared_force_on || comparator_request
                || output_conv_request;
        end
    end

    // ----------------------------------------------------------------
    // Level outputs follow the select fields
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_level_q <= `VRC_LVL_0V55;
            shared_level_q <= `VRC_LVL_0V55;
        end else begin
            converter_level_q <= src_sel[0];
            shared_level_q <= src_sel[1];
        end
    end

    // ----------------------------------------------------------------
    // Level decoders, one per source
    // ----------------------------------------------------------------
    assign src_sel[0] = level_select_register_q[`VRC_CONV_SEL_HI:`VRC_CONV_SEL_LO];
    assign src_sel[1] = level_select_register_q[`VRC_SHARED_SEL_HI:`VRC_SHARED_SEL_LO];

    generate
        for (gi = 0; gi < SRC_COUNT; gi = gi + 1) begin : g_src
            vrc_level_decode u_decode (
                .aclk(aclk),
                .aresetn(aresetn),
                .sel(src_sel[gi]),
                .level_onehot_q(src_onehot[gi])
            );
        end
    endgenerate

    assign converter_level_onehot_q = src_onehot[0];
    assign shared_level_onehot_q = src_onehot[1];
endmodule // vrc_reference_control

// file: test/vrc_monitor.sv
// Checker for reference enables and level outputs
`timescale 1ns/1ns
module vrc_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire s_axi_rvalid,
    input wire converter_request,
    input wire comparator_request,
    input wire output_conv_request,
    input wire converter_ref_en_q,
    input wire shared_ref_en_q,
    input wire [2:0] converter_level_q,
    input wire [2:0] shared_level_q,
    input wire [4:0] converter_level_onehot_q,
    input wire [4:0] shared_level_onehot_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    function automatic logic [4:0] vrc_dec(input logic [2:0] c);
        return (c > 3'h3) ? 5'h10 : (5'h01 << c);
    endfunction
    sequence s_conv_steady; $stable(converter_level_q) [*2]; endsequence
    sequence s_shr_steady; $stable(shared_level_q) [*2]; endsequence
    property p_conv_req; converter_request |=> converter_ref_en_q; endproperty
    a_conv_req: assert property (p_conv_req) else $error("conv enable late");
    property p_shr_req; (comparator_request || output_conv_request) |=> shared_ref_en_q; endproperty
    a_shr_req: assert property (p_shr_req) else $error("shared enable late");
    property p_conv_off; $fell(converter_ref_en_q) |-> !$past(converter_request); endproperty
    a_conv_off: assert property (p_conv_off) else $error("conv off while wanted");
    property p_shr_off;
        $fell(shared_ref_en_q) |-> !$past(comparator_request || output_conv_request);
    endproperty
    a_shr_off: assert property (p_shr_off) else $error("shared off while wanted");
    property p_conv_dec;
        s_conv_steady |-> converter_level_onehot_q == vrc_dec(converter_level_q);
    endproperty
    a_conv_dec: assert property (p_conv_dec) else $error("conv level decode");
    property p_shr_dec; s_shr_steady |-> shared_level_onehot_q == vrc_dec(shared_level_q);
    endproperty
    a_shr_dec: assert property (p_shr_dec) else $error("shared level decode");
    property p_rst; $rose(aresetn) |-> !converter_ref_en_q && !shared_ref_en_q &&
        converter_level_q == 3'h0 && shared_level_onehot_q == 5'h01 && !s_axi_bvalid &&
        !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_sel;
        $changed({converter_level_q, shared_level_q}) |-> $past(s_axi_bvalid);
    endproperty
    a_sel: assert property (p_sel) else $error("level moved without write");
endmodule // vrc_monitor
bind vrc_reference_control vrc_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
    .converter_request(converter_request), .comparator_request(comparator_request),
    .output_conv_request(output_conv_request), .converter_ref_en_q(converter_ref_en_q),
    .shared_ref_en_q(shared_ref_en_q), .converter_level_q(converter_level_q),
    .shared_level_q(shared_level_q), .converter_level_onehot_q(converter_level_onehot_q),
    .shared_level_onehot_q(shared_level_onehot_q));

// file: test/vrc_req_src.sv
// Request sources of the converter, comparator and output converter
`timescale 1ns/1ns
module vrc_req_src (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] want,
    output reg converter_request,
    output reg comparator_request,
    output reg output_conv_request
);
    always @(posedge aclk) begin
        {converter_request, comparator_request, output_conv_request} <= aresetn ? want : 3'h0;
    end
endmodule // vrc_req_src

// file: test/voltage_reference_control_tb.sv
// Bench for the reference control block
`timescale 1ns/1ns
`include "vrc_regs.vh"
module voltage_reference_control_tb;
    logic aclk, awr, wrd, bv, arr, rv, creq, cmreq, oreq, cen, sen;
    logic aresetn = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
    logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hF;
    logic [31:0] wd = 32'h0, rdat;
    logic [2:0] want = 3'h0, clv, slv;
    logic [1:0] br, rr;
    logic [4:0] coh, soh;
    int miscompares = 0;
    int n_checks = 0;
    vrc_req_src i_src (.aclk(aclk), .aresetn(aresetn), .want(want), .converter_request(creq),
        .comparator_request(cmreq), .output_conv_request(oreq));
    vrc_reference_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'h1), .converter_request(creq),
        .comparator_request(cmreq), .output_conv_request(oreq), .converter_ref_en_q(cen),
        .shared_ref_en_q(sen), .converter_level_q(clv), .shared_level_q(slv),
        .converter_level_onehot_q(coh), .shared_level_onehot_q(soh));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        awa <= a;
        wd <= {24'h0, d};
        {awv, wv} <= 2'h3;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
        end while (bv !== 1'h1);
        chk("bresp", {30'h0, br}, {30'h0, er});
        repeat (2) @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        ara <= a;
        arv <= 1'h1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
        end while (rv !== 1'h1);
        chk("rdata", rdat, ed);
        chk("rresp", {30'h0, rr}, {30'h0, er});
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_levels;
        for (int i = 0; i < 8; i++) begin
            logic [2:0] c;
            c = 3'(i);
            wr(`VRC_LEVEL_SELECT_ADDR, {1'h1, c, 1'h1, ~c}, `VRC_RESP_OKAY);
            chk("conv_lvl", {29'h0, clv}, {29'h0, c});
            chk("shr_lvl", {29'h0, slv}, {29'h0, ~c});
            chk("conv_oh", {27'h0, coh}, (c > 3'h3) ? 32'h10 : 32'h1 << c);
            chk("shr_oh", {27'h0, soh}, (~c > 3'h3) ? 32'h10 : 32'h1 << ~c);
            rd(`VRC_LEVEL_SELECT_ADDR, {25'h0, c, 1'h0, ~c}, `VRC_RESP_OKAY);
        end
    endtask
    task automatic t_req;
        for (int i = 0; i < 4; i++) begin
            want <= 3'h4 >> i;
            repeat (3) @(posedge aclk);
            chk("conv_en", {31'h0, cen}, {31'h0, want[2]});
            chk("shr_en", {31'h0, sen}, {31'h0, |want[1:0]});
        end
    endtask
    task automatic t_force;
        for (int i = 1; i < 5; i++) begin
            logic [1:0] f;
            f = 2'(i);
            wr(`VRC_FORCE_ENABLE_ADDR, {6'h3F, f}, `VRC_RESP_OKAY);
            chk("conv_en", {31'h0, cen}, {31'h0, f[1]});
            chk("shr_en", {31'h0, sen}, {31'h0, f[0]});
            rd(`VRC_FORCE_ENABLE_ADDR, {30'h0, f}, `VRC_RESP_OKAY);
        end
    endtask
    task automatic t_rst;
        wr(`VRC_LEVEL_SELECT_ADDR, 8'h33, `VRC_RESP_OKAY);
        wr(`VRC_FORCE_ENABLE_ADDR, 8'h03, `VRC_RESP_OKAY);
        ws <= 4'h0;
        wr(`VRC_FORCE_ENABLE_ADDR, 8'h00, `VRC_RESP_OKAY);
        ws <= 4'hF;
        rd(`VRC_FORCE_ENABLE_ADDR, 32'h3, `VRC_RESP_OKAY);
        chk("conv_en", {31'h0, cen}, 32'h1);
        wr(4'h8, 8'h55, `VRC_RESP_SLVERR);
        rd(4'hC, 32'h0, `VRC_RESP_SLVERR);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`VRC_LEVEL_SELECT_ADDR, 32'h0, `VRC_RESP_OKAY);
        rd(`VRC_FORCE_ENABLE_ADDR, 32'h0, `VRC_RESP_OKAY);
        chk("conv_oh", {27'h0, coh}, 32'h01);
        chk("conv_en", {31'h0, cen}, 32'h0);
        chk("shr_en", {31'h0, sen}, 32'h0);
        chk("shr_lvl", {29'h0, slv}, 32'h0);
    endtask
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`VRC_LEVEL_SELECT_ADDR, 32'h0, `VRC_RESP_OKAY);
        t_levels();
        t_req();
        t_force();
        t_rst();
        summarize();
    end
endmodule // voltage_reference_control_tb
